// ### hw/wlf_status_regs.sv
// Wake-level and high-side switch fault status registers, read by the host.
// Assumes the serial frame logic issues one-cycle read requests on clk_i and
// that mode, cyclic sampling, soft reset and restart come from logic on clk_i.
//
// How it works
// R01 - Wake level bits 3:0 show wake inputs four to one, 1 means high.
// R02 - Wake levels follow the inputs in normal, stop, init and restart modes.
// R03 - In cyclic sense or wake, bits load at each sample and hold between.
// R04 - Reserved bits of both status registers always read zero.
// R05 - Power-on, soft reset or restart clears all wake level bits.
// R06 - Fault bits 13:10 flag overtemperature on switches four to one, clear on read.
// R07 - Fault bits 8:5 flag open load on switches four to one, clear on read.
// R08 - Fault bits 3:0 flag overcurrent on switches four to one, clear on read.
// R09 - Power-on or soft reset clears fault flags; restart keeps them.
// R10 - Flags stay set after faults vanish; a fault present at read sets again.
module wlf_status_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  input wire logic restart_i,
  input wire wlf_pkg::wlf_mode_type dev_mode_i,
  input wire logic cyclic_active_i,
  input wire logic sample_strobe_i,
  input wire logic [3:0] wake_in_i,
  input wire logic [3:0] hs_overtemp_i,
  input wire logic [3:0] hs_open_load_i,
  input wire logic [3:0] hs_overcurrent_i,
  input wire logic rd_req_i,
  input wire logic [6:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Wake pins and analog detector outputs are asynchronous to clk_i.
  logic [15:0] meta_r;
  logic [15:0] sync_r;
  logic [3:0] wake_s;
  logic [11:0] fault_s;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= 16'h0000;
      sync_r <= 16'h0000;
    end else begin
      meta_r <= {hs_overtemp_i, hs_open_load_i, hs_overcurrent_i, wake_in_i};
      sync_r <= meta_r;
    end
  end

  assign wake_s = sync_r[3:0];
  assign fault_s = sync_r[15:4];

  // ----------------------------------------------------------------
  // Wake level register
  // ----------------------------------------------------------------
  logic [3:0] wake_r;
  logic [3:0] wake_nxt;
  logic mode_live;

  // Sleep and fail-safe freeze the last seen level unless cyclic sampling runs.
  always_comb begin
    unique case (dev_mode_i)
      wlf_pkg::MODE_NORMAL,
      wlf_pkg::MODE_STOP,
      wlf_pkg::MODE_INIT,
      wlf_pkg::MODE_RESTART: mode_live = 1'b1;
      default: mode_live = 1'b0;
    endcase
  end

  always_comb begin
    wake_nxt = wake_r;
    if (soft_rst_i || restart_i) begin
      wake_nxt = wlf_pkg::WAKE_LEVEL_RST; // [R05]
    end else if (cyclic_active_i) begin
      if (sample_strobe_i) begin
        wake_nxt = wake_s; // [R03]
      end
    end else if (mode_live) begin
      wake_nxt = wake_s; // [R01] [R02]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_r <= wlf_pkg::WAKE_LEVEL_RST; // [R05]
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault flag store
  // ----------------------------------------------------------------
  wlf_fault_if fault_bus ();
  logic fault_hit;

  assign fault_hit = rd_req_i && (rd_addr_i == wlf_pkg::HS_FAULT_ADDR);
  assign fault_bus.set = fault_s;
  assign fault_bus.clr = fault_hit; // [R06] [R07] [R08]
  assign fault_bus.soft_clr = soft_rst_i; // [R09]

  wlf_fault_flags u_flags (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(fault_bus)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [11:0] fl;

  assign fl = fault_bus.flags;

  // The snapshot is taken from the flags before the clear, so the read sees them.
  always_comb begin
    rd_valid_nxt = rd_req_i;
    rd_data_nxt = wlf_pkg::READ_ZERO;
    if (rd_req_i && rd_addr_i == wlf_pkg::WAKE_LEVEL_ADDR) begin
      rd_data_nxt[wlf_pkg::WAKE_LSB +: 4] = wake_r; // [R01] [R04]
    end else if (fault_hit) begin
      rd_data_nxt[wlf_pkg::OT_LSB +: 4] = fl[wlf_pkg::FLAG_OT_LSB +: 4]; // [R06]
      rd_data_nxt[wlf_pkg::OL_LSB +: 4] = fl[wlf_pkg::FLAG_OL_LSB +: 4]; // [R07]
      rd_data_nxt[wlf_pkg::OC_LSB +: 4] = fl[wlf_pkg::FLAG_OC_LSB +: 4]; // [R08] [R04]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= wlf_pkg::READ_ZERO;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_valid_o = rd_valid_r;
  assign rd_data_o = rd_data_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_wake_read;
    rd_req_i && rd_addr_i == wlf_pkg::WAKE_LEVEL_ADDR;
  endsequence

  sequence s_fault_read;
    rd_req_i && rd_addr_i == wlf_pkg::HS_FAULT_ADDR;
  endsequence

  a_wake_read_map: assert property ( // [R01]
    s_wake_read |=> rd_valid_o && rd_data_o == {12'h000, $past(wake_r)})
    else $error("wake level read data wrong");

  a_wake_live_follow: assert property ( // [R02]
    (mode_live && !cyclic_active_i && !soft_rst_i && !restart_i) |=> wake_r == $past(wake_s))
    else $error("wake level not refreshed in live mode");

  a_wake_cyclic_hold: assert property ( // [R03]
    (cyclic_active_i && !sample_strobe_i && !soft_rst_i && !restart_i) |=> $stable(wake_r))
    else $error("wake level changed between samples");

  a_wake_cyclic_load: assert property ( // [R03]
    (cyclic_active_i && sample_strobe_i && !soft_rst_i && !restart_i) |=> wake_r == $past(wake_s))
    else $error("wake level not loaded at sample");

  a_read_reserved_zero: assert property ( // [R04]
    rd_valid_o |-> (rd_data_o[15:14] == 2'b00 && !rd_data_o[9] && !rd_data_o[4]
                    && (rd_data_o[13:4] == 10'h000 || $past(fault_hit))))
    else $error("reserved bit read as one");

  a_wake_reset_clear: assert property ( // [R05]
    (soft_rst_i || restart_i) |=> wake_r == 4'h0)
    else $error("wake level not cleared by reset");

  a_fault_read_data: assert property ( // [R08]
    s_fault_read |=> rd_valid_o && rd_data_o == {2'b00, $past(fl[11:8]), 1'b0,
                                                $past(fl[7:4]), 1'b0, $past(fl[3:0])})
    else $error("fault read data wrong");

  a_fault_read_refire: assert property ( // [R10]
    (s_fault_read and (fault_s != 12'h000) and !soft_rst_i) |=> fl == $past(fault_s))
    else $error("present fault not flagged again after read");

  a_restart_keeps: assert property ( // [R09]
    (restart_i && !soft_rst_i && !fault_hit) |=> ((fl & $past(fl)) == $past(fl)))
    else $error("restart lost fault flags");

  a_unmapped_zero: assert property ( // [R04]
    (rd_req_i && rd_addr_i != wlf_pkg::WAKE_LEVEL_ADDR && !fault_hit) |=> rd_data_o == 16'h0000)
    else $error("unmapped address read nonzero");

  // The host captures data only in the answer cycle, so stray data or a late answer would be
  // taken as a wrong read or lost entirely.
  a_read_valid_track: assert property ( // [R04]
    rd_valid_o == $past(rd_req_i))
    else $error("read answer not one cycle after request");

  a_idle_data_zero: assert property ( // [R04]
    !rd_valid_o |-> rd_data_o == 16'h0000)
    else $error("read data nonzero outside an answer");

  a_wake_frozen_hold: assert property ( // [R02]
    (!mode_live && !cyclic_active_i && !soft_rst_i && !restart_i) |=> $stable(wake_r))
    else $error("wake level changed in a non-updating mode");

  a_fault_soft_clear: assert property ( // [R09]
    soft_rst_i |=> fl == 12'h000)
    else $error("soft reset did not reach the fault flags");

endmodule

// ### hw/wlf_pkg.sv
// Shared constants and types for the wake-level and switch-fault status block.
// Assumes a 125 MHz system clock and 7-bit register addresses with 16-bit data.
package wlf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] WAKE_LEVEL_ADDR = 7'h45;
  localparam logic [6:0] HS_FAULT_ADDR = 7'h46;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int N_IN = 4;
  localparam int FLAG_W = 12;
  localparam int WAKE_LSB = 0;
  localparam int OC_LSB = 0;
  localparam int OL_LSB = 5;
  localparam int OT_LSB = 10;
  // Positions of the three groups inside the packed flag vector.
  localparam int FLAG_OC_LSB = 0;
  localparam int FLAG_OL_LSB = 4;
  localparam int FLAG_OT_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] WAKE_LEVEL_RST = 4'h0;
  localparam logic [11:0] HS_FAULT_RST = 12'h000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Operating modes reported by the mode controller
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_INIT,
    MODE_RESTART,
    MODE_FAIL_SAFE
  } wlf_mode_type;

endpackage

// ### hw/wlf_fault_if.sv
// Interface between the status register top and its sticky fault flag store.
// Assumes both ends run on the same clock.
interface wlf_fault_if;
  logic [11:0] set;
  logic clr;
  logic soft_clr;
  logic [11:0] flags;

  modport owner (
    input set,
    input clr,
    input soft_clr,
    output flags
  );

  modport user (
    output set,
    output clr,
    output soft_clr,
    input flags
  );
endinterface

// ### hw/wlf_fault_flags.sv
// Sticky, clear-on-read fault flags for four high-side switches.
// Assumes set inputs are already synchronised to clk_i.
module wlf_fault_flags (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  wlf_fault_if.owner bus
);

  logic [11:0] flag_r;
  logic [11:0] flag_nxt;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // A detection in the cycle of the clearing read survives, so no fault is lost.
  for (genvar i = 0; i < wlf_pkg::FLAG_W; i++) begin : g_flag
    always_comb begin
      if (bus.soft_clr) begin
        flag_nxt[i] = 1'b0; // [R09]
      end else begin
        flag_nxt[i] = (flag_r[i] & ~bus.clr) | bus.set[i]; // [R06] [R07] [R08] [R10]
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_r <= wlf_pkg::HS_FAULT_RST; // [R09]
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign bus.flags = flag_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_flag_set_wins: assert property ( // [R10]
    (bus.set != 12'h000 && !bus.soft_clr) |=> ((flag_r & $past(bus.set)) == $past(bus.set)))
    else $error("fault event lost");

  a_flag_sticky_hold: assert property ( // [R06]
    (!bus.clr && !bus.soft_clr) |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
    else $error("fault flag dropped without a read");

  a_flag_read_clear: assert property ( // [R07]
    (bus.clr && !bus.soft_clr) |=> (flag_r == $past(bus.set)))
    else $error("read did not clear fault flags");

  a_flag_soft_clear: assert property ( // [R09]
    bus.soft_clr |=> (flag_r == 12'h000))
    else $error("soft reset left fault flags set");

endmodule

// ### verification/wlf_host_model.sv
// Host-side reader model for the wake-level and switch-fault status registers.
// Assumes one read command at a time from the bench, all on clk_i.
module wlf_host_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  output logic rd_req_o,
  output logic [6:0] rd_addr_o,
  output logic done_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Request and capture
  // ----------------------------------------------------------------
  // The address toggles while idle, so a design that samples it outside a request misreads.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= 7'h00;
      done_o <= 1'b0;
      data_o <= 16'h0000;
    end else begin
      rd_req_o <= go_i;
      rd_addr_o <= go_i ? addr_i : ~rd_addr_o;
      done_o <= rd_valid_i;
      if (rd_valid_i) begin
        data_o <= rd_data_i;
      end
    end
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the status register block, read through a host model.
// Assumes the one-cycle read answer and three-edge input path of the design.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] ctl = 3'h0;
  wlf_pkg::wlf_mode_type mode = wlf_pkg::MODE_NORMAL;
  logic cyc = 1'b0;
  logic [3:0] wake = 4'h0;
  logic [3:0] ot = 4'h0;
  logic [3:0] ol = 4'h0;
  logic [3:0] oc = 4'h0;
  logic go = 1'b0;
  logic [6:0] addr = 7'h00;
  logic req, vld, done;
  logic [6:0] raddr;
  logic [15:0] rdata, hdata;
  int failures = 0;
  int total_checks = 0;
  wlf_pkg::wlf_mode_type ml [4];
  logic [3:0] wv [4];

  always #4 clk_i = ~clk_i;

  wlf_status_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(ctl[2]),
    .restart_i(ctl[1]), .dev_mode_i(mode), .cyclic_active_i(cyc), .sample_strobe_i(ctl[0]),
    .wake_in_i(wake), .hs_overtemp_i(ot), .hs_open_load_i(ol), .hs_overcurrent_i(oc),
    .rd_req_i(req), .rd_addr_i(raddr), .rd_valid_o(vld), .rd_data_o(rdata));

  wlf_host_model host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .addr_i(addr),
    .rd_valid_i(vld), .rd_data_i(rdata), .rd_req_o(req), .rd_addr_o(raddr),
    .done_o(done), .data_o(hdata));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [6:0] a, input logic [15:0] e);
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 10);
    total_checks++;
    if (done !== 1'b1 || hdata !== e) begin
      failures++;
      $display("ERROR t=%0t read %h got %h want %h", $time, a, hdata, e);
      if (done !== 1'b1) begin
        give_verdict();
      end
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    ctl[k] <= 1'b1;
    @(posedge clk_i);
    ctl[k] <= 1'b0;
  endtask

  // Four edges cover the synchroniser plus the register load.
  task automatic flt(input logic [3:0] t, input logic [3:0] l, input logic [3:0] c);
    @(posedge clk_i);
    ot <= t;
    ol <= l;
    oc <= c;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wk(input wlf_pkg::wlf_mode_type m, input logic [3:0] v);
    @(posedge clk_i);
    mode <= m;
    wake <= v;
    repeat (4) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ml = '{wlf_pkg::MODE_NORMAL, wlf_pkg::MODE_STOP, wlf_pkg::MODE_INIT, wlf_pkg::MODE_RESTART};
    wv = '{4'hA, 4'h5, 4'h3, 4'hC};
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(7'h45, 16'h0000);
    chk(7'h46, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wk(ml[i], wv[i]);
      chk(7'h45, {12'h000, wv[i]});
    end
    wk(wlf_pkg::MODE_SLEEP, 4'h0);
    chk(7'h45, 16'h000C);
    wk(wlf_pkg::MODE_FAIL_SAFE, 4'h6);
    chk(7'h45, 16'h000C);
    pulse(1);
    chk(7'h45, 16'h0000);
    @(posedge clk_i);
    cyc <= 1'b1;
    wk(wlf_pkg::MODE_NORMAL, 4'h9);
    chk(7'h45, 16'h0000);
    pulse(0);
    chk(7'h45, 16'h0009);
    wk(wlf_pkg::MODE_NORMAL, 4'h2);
    chk(7'h45, 16'h0009);
    @(posedge clk_i);
    cyc <= 1'b0;
    flt(4'h9, 4'h6, 4'hF);
    flt(4'h0, 4'h0, 4'h0);
    chk(7'h46, 16'h24CF);
    chk(7'h46, 16'h0000);
    flt(4'h0, 4'h0, 4'h1);
    chk(7'h46, 16'h0001);
    chk(7'h46, 16'h0001);
    flt(4'h0, 4'h0, 4'h0);
    chk(7'h46, 16'h0001);
    chk(7'h46, 16'h0000);
    flt(4'h0, 4'h8, 4'h0);
    flt(4'h0, 4'h0, 4'h0);
    pulse(1);
    chk(7'h46, 16'h0100);
    wk(wlf_pkg::MODE_NORMAL, 4'hF);
    wk(wlf_pkg::MODE_SLEEP, 4'hF);
    flt(4'h8, 4'h0, 4'h0);
    flt(4'h0, 4'h0, 4'h0);
    pulse(2);
    chk(7'h45, 16'h0000);
    chk(7'h46, 16'h0000);
    flt(4'h2, 4'h0, 4'h0);
    flt(4'h0, 4'h0, 4'h0);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(7'h46, 16'h0000);
    chk(7'h44, 16'h0000);
    chk(7'h47, 16'h0000);
    give_verdict();
  end
endmodule
